// *** src/umc_pkg.sv ***
/*
  umc_pkg: shared constants for the uart modem-control line block.
  assumes a 100 MHz system clock; all modem pins are active low.
*/
package umc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned WAKE_MS        = 20;
  localparam int unsigned WAKE_CYC       = (CLK_HZ / 1000) * WAKE_MS;
  localparam int unsigned STOP_CHARS     = 2;

  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  localparam logic        PIN_ON         = 1'b0;
  localparam logic        PIN_OFF        = 1'b1;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADR_CTRL       = 4'h0;
  localparam logic [3:0]  ADR_CALL       = 4'h4;
  localparam logic [3:0]  ADR_STAT       = 4'h8;

  // control register fields
  localparam int unsigned CTRL_HWFC      = 0;
  localparam int unsigned CTRL_MUX       = 1;
  localparam int unsigned CTRL_DSR_TRK   = 2;
  localparam int unsigned CTRL_DCD_TRK   = 3;
  localparam int unsigned CTRL_PSV_LSB   = 4;
  localparam int unsigned CTRL_PSV_W     = 2;
  localparam int unsigned CTRL_UART_RDY  = 6;
  // reset: hw flow control on, tracking dsr and dcd, power save off, uart ready
  localparam logic [31:0] CTRL_RST       = 32'h0000_004d;

  // call/mode register fields
  localparam int unsigned CALL_MODE_LSB  = 0;
  localparam int unsigned CALL_MODE_W    = 2;
  localparam int unsigned CALL_VOICE     = 2;
  localparam int unsigned CALL_PKT       = 3;
  localparam int unsigned CALL_CSD       = 4;
  localparam int unsigned CALL_PROMPT    = 5;
  localparam int unsigned CALL_CARRIER   = 6;
  localparam logic [31:0] CALL_RST       = 32'h0000_0000;

  // interface mode codes
  localparam logic [1:0]  MODE_CMD       = 2'h0;
  localparam logic [1:0]  MODE_DATA      = 2'h1;
  localparam logic [1:0]  MODE_ONLINE    = 2'h2;

  // power save codes
  localparam logic [1:0]  PSV_OFF        = 2'h0;
  localparam logic [1:0]  PSV_CYCLIC     = 2'h1;
  localparam logic [1:0]  PSV_RTS        = 2'h2;
  localparam logic [1:0]  PSV_DTR        = 2'h3;

  // status register fields
  localparam int unsigned STAT_UART_EN   = 0;
  localparam int unsigned STAT_AWAKE     = 1;
  localparam int unsigned STAT_TX_PAUSE  = 2;
  localparam int unsigned STAT_DROP1ST   = 3;
  localparam int unsigned STAT_RTS_ON    = 4;
  localparam int unsigned STAT_DTR_ON    = 5;

  typedef enum logic [1:0] {
    UMC_WAKE_IDLE,
    UMC_WAKE_WAIT,
    UMC_WAKE_UP
  } umc_wake_e;

endpackage : umc_pkg

// *** src/umc_sync.sv ***
/*
  umc_sync: two flip-flop synchroniser for an asynchronous pin.
  assumes the pin is idle high (internal pull-up); resets to idle.
*/
`timescale 1ns/1ps
module umc_sync
  import umc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      sync_o
);

  logic meta_q;

  // ----------------------------------------------------------------
  // two stages; only the second stage is seen outside
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= PIN_OFF;
      sync_o <= PIN_OFF;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule : umc_sync

// *** src/umc_wake.sv ***
/*
  umc_wake: wake timer for the pin-controlled power save modes.
  assumes ctl_on_i is a synchronised level, high while the line is ON.
*/
`timescale 1ns/1ps
module umc_wake
  import umc_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic arm_i,
  input  wire logic ctl_on_i,
  output logic      uart_en_o,
  output logic      ready_o
);

  localparam int unsigned CW = $clog2(WAKE_CYCLES + 1);

  umc_wake_e        state_q;
  logic             prev_q;
  logic [CW-1:0]    cnt_q;
  logic             rise;

  // only an OFF-to-ON edge wakes; a line already ON at arm time does not
  assign rise = ctl_on_i & ~prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= ctl_on_i;
    end
  end

  // ----------------------------------------------------------------
  // wake sequence: edge enables uart, wait settles before lossless rx
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= UMC_WAKE_IDLE;
      cnt_q   <= '0;
    end else if (!arm_i || !ctl_on_i) begin
      state_q <= UMC_WAKE_IDLE;          // line OFF: disable uart, allow idle
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        UMC_WAKE_IDLE: begin
          if (rise) begin
            state_q <= UMC_WAKE_WAIT;
            cnt_q   <= CW'(WAKE_CYCLES - 1);
          end
        end
        UMC_WAKE_WAIT: begin
          if (cnt_q == '0) begin
            state_q <= UMC_WAKE_UP;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        UMC_WAKE_UP: begin
          state_q <= UMC_WAKE_UP;
        end
      endcase
    end
  end

  assign uart_en_o = (state_q != UMC_WAKE_IDLE);
  assign ready_o   = (state_q == UMC_WAKE_UP);

endmodule : umc_wake

// *** src/umc_lines.sv ***
/*
  umc_lines: modem-control lines (cts, rts, dsr, dtr, dcd) of a dce uart.
  holds flow control, dsr/dcd modes, carrier request merging and the
  rts/dtr controlled power save wake. registers over classic wishbone.
  assumes the uart core reports received characters, tx character ends and tx requests.
*/
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module umc_lines
  import umc_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // modem pins, active low; pull-up enables active high
  input  wire logic        rts_n_i,
  input  wire logic        dtr_n_i,
  output logic             cts_n_o,
  output logic             dsr_n_o,
  output logic             dcd_n_o,
  output logic             rts_pullup_o,
  output logic             dtr_pullup_o,
  // uart core side
  input  wire logic        rx_char_i,
  input  wire logic        tx_char_done_i,
  input  wire logic        tx_req_i,
  output logic             tx_allow_o,
  output logic             rx_drop_o,
  output logic             mux_fc_on_o,
  output logic             uart_en_o,
  output logic             awake_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] call_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  logic        hwfc;
  logic        mux_on;
  logic [1:0]  psv;
  logic [1:0]  mode;
  logic        uart_rdy;

  assign hwfc     = ctrl_q[CTRL_HWFC];
  assign mux_on   = ctrl_q[CTRL_MUX];
  assign psv      = ctrl_q[CTRL_PSV_LSB +: CTRL_PSV_W];
  assign uart_rdy = ctrl_q[CTRL_UART_RDY];
  assign mode     = call_q[CALL_MODE_LSB +: CALL_MODE_W];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rts_n_s;
  logic dtr_n_s;
  logic rts_on;
  logic dtr_on;

  umc_sync u_rts_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (rts_n_i),
    .sync_o (rts_n_s)
  );

  umc_sync u_dtr_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (dtr_n_i),
    .sync_o (dtr_n_s)
  );

  // synchronisers reset to OFF, so both lines read OFF at init
  assign rts_on = (rts_n_s == PIN_ON);
  assign dtr_on = (dtr_n_s == PIN_ON);

  // internal pull-ups always enabled; the host overrides by driving
  assign rts_pullup_o = 1'b1;
  assign dtr_pullup_o = 1'b1;

  // ----------------------------------------------------------------
  // power save wake (rts or dtr controlled)
  // ----------------------------------------------------------------
  logic psv_rts;
  logic psv_dtr;
  logic wake_on;
  logic wake_en;
  logic wake_rdy;

  // rts control only with flow control off; rts then means wake, not flow
  assign psv_rts = (psv == PSV_RTS) & ~hwfc;
  assign psv_dtr = (psv == PSV_DTR);
  assign wake_on = psv_rts ? rts_on : dtr_on;

  umc_wake #(
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_wake (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .arm_i     (psv_rts | psv_dtr),
    .ctl_on_i  (wake_on),
    .uart_en_o (wake_en),
    .ready_o   (wake_rdy)
  );

  // uart powered: always when power save off; cyclic mode leans on software
  always_comb begin
    unique case (psv)
      PSV_OFF:    uart_en_o = 1'b1;
      PSV_CYCLIC: uart_en_o = uart_rdy;
      PSV_RTS:    uart_en_o = hwfc ? uart_rdy : wake_en;
      PSV_DTR:    uart_en_o = wake_en;
    endcase
  end

  // module forced active while the controlling line keeps it awake
  assign awake_o = (psv == PSV_OFF) | wake_en;

  // ----------------------------------------------------------------
  // first-character loss in power save without flow control
  // ----------------------------------------------------------------
  logic drop_q;

  // a character while asleep only wakes the uart; it is not data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_q <= 1'b0;
    end else if (psv == PSV_OFF || hwfc) begin
      drop_q <= 1'b0;
    end else if (rx_char_i && !uart_en_o) begin
      drop_q <= 1'b1;
    end else if (uart_en_o && (psv != PSV_RTS) && (psv != PSV_DTR)) begin
      drop_q <= 1'b0;
    end else if (wake_rdy) begin
      drop_q <= 1'b0;
    end
  end

  // incomplete wake: received characters are not guaranteed valid
  assign rx_drop_o = ~hwfc & (psv != PSV_OFF) &
                     (~uart_en_o | ((psv_rts | psv_dtr) & ~wake_rdy));

  // ----------------------------------------------------------------
  // cts: accept indication, or uart power only under mux
  // ----------------------------------------------------------------
  logic cts_on;

  always_comb begin
    if (!hwfc) begin
      cts_on = 1'b1;
    end else if (mux_on) begin
      cts_on = uart_en_o;
    end else begin
      cts_on = uart_en_o & uart_rdy;
    end
  end

  // flow control towards the host travels in mux commands when mux is on
  assign mux_fc_on_o = hwfc & mux_on & uart_rdy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_n_o <= PIN_ON;
    end else begin
      cts_n_o <= cts_on ? PIN_ON : PIN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // tx pause on rts OFF
  // ----------------------------------------------------------------
  logic [1:0] ovr_q;
  logic       pause;

  // characters sent after rts went OFF; the in-flight one always ends
  assign pause = hwfc & ~rts_on;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_q <= '0;
    end else if (!pause) begin
      ovr_q <= '0;
    end else if (tx_char_done_i && (ovr_q != 2'(STOP_CHARS))) begin
      ovr_q <= ovr_q + 2'd1;
    end
  end

  // start of a new character is refused at once; at most one more ends
  assign tx_allow_o = tx_req_i & ~pause & (ovr_q < 2'(STOP_CHARS));

  // ----------------------------------------------------------------
  // dsr
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsr_n_o <= PIN_OFF;
    end else if (!ctrl_q[CTRL_DSR_TRK]) begin
      dsr_n_o <= PIN_ON;
    end else begin
      dsr_n_o <= (mode == MODE_DATA) ? PIN_ON : PIN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // dcd: or of every requester
  // ----------------------------------------------------------------
  logic dcd_req;

  assign dcd_req = call_q[CALL_CARRIER]
                 | call_q[CALL_VOICE]
                 | (call_q[CALL_PKT] & (mode == MODE_DATA))
                 | (call_q[CALL_CSD] & (mode != MODE_CMD))
                 | call_q[CALL_PROMPT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcd_n_o <= PIN_OFF;
    end else if (!ctrl_q[CTRL_DCD_TRK]) begin
      dcd_n_o <= PIN_ON;
    end else begin
      dcd_n_o <= dcd_req ? PIN_ON : PIN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic wr;

  // single-wait-state ack; ack drops for a cycle so each access acks once
  // a write lands on the edge that samples ack, as a classic master expects
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // control register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr && wb_adr_i == ADR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // call and interface mode register, written by the command engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      call_q <= CALL_RST;
    end else if (wr && wb_adr_i == ADR_CALL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          call_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // read mux; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (req) begin
      rdat_q <= '0;
      unique case (wb_adr_i)
        ADR_CTRL: rdat_q <= ctrl_q & 32'h0000_007f;
        ADR_CALL: rdat_q <= call_q & 32'h0000_007f;
        ADR_STAT: begin
          rdat_q[STAT_UART_EN]  <= uart_en_o;
          rdat_q[STAT_AWAKE]    <= wake_rdy;
          rdat_q[STAT_TX_PAUSE] <= pause;
          rdat_q[STAT_DROP1ST]  <= drop_q;
          rdat_q[STAT_RTS_ON]   <= rts_on;
          rdat_q[STAT_DTR_ON]   <= dtr_on;
        end
        default: rdat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : umc_lines

// *** verif/umc_lines_asserts.sv ***
/*
  umc_lines_asserts: port checker for umc_lines.
  assumes a bind from the bench; ctrl and call are shadowed from bus writes.
*/
`timescale 1ns/1ps
module umc_lines_asserts
  import umc_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        rts_n_i,
  input wire logic        dtr_n_i,
  input wire logic        cts_n_o,
  input wire logic        dsr_n_o,
  input wire logic        dcd_n_o,
  input wire logic        rts_pullup_o,
  input wire logic        dtr_pullup_o,
  input wire logic        tx_allow_o,
  input wire logic        mux_fc_on_o,
  input wire logic        uart_en_o,
  input wire logic        rx_drop_o,
  input wire logic        awake_o
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, call_q, on_cnt_q;
  logic [1:0]  psv, mode;
  logic        wr, req, psv_mode, pin_n, pin_q;

  // only byte 0 carries fields, so only lane 0 is shadowed
  // a write lands on the edge at which ack is high
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign psv = ctrl_q[CTRL_PSV_LSB +: CTRL_PSV_W];
  assign mode = call_q[1:0];
  assign req = call_q[CALL_VOICE] | call_q[CALL_PROMPT] | call_q[CALL_CARRIER]
             | (call_q[CALL_PKT] & (mode == MODE_DATA))
             | (call_q[CALL_CSD] & (mode == MODE_DATA || mode == MODE_ONLINE));
  assign psv_mode = (psv == PSV_RTS && !ctrl_q[CTRL_HWFC]) || psv == PSV_DTR;
  assign pin_n = (psv == PSV_DTR) ? dtr_n_i : rts_n_i;

  // register shadow, updated at the edge that takes the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      call_q <= CALL_RST;
    end else if (wr && wb_adr_i == ADR_CTRL) begin
      ctrl_q[7:0] <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == ADR_CALL) begin
      call_q[7:0] <= wb_dat_i[7:0];
    end
  end

  // cycles the control line has been ON since an OFF-to-ON edge
  // counting only after an OFF sample avoids a false wake with no edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !psv_mode || pin_n) begin
      on_cnt_q <= '0;
    end else if ((on_cnt_q != 0 || pin_q) && on_cnt_q < WAKE_CYCLES + 10) begin
      on_cnt_q <= on_cnt_q + 1;
    end
    pin_q <= !rst_i && psv_mode && pin_n;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  init_lines_a: assert property (
    $fell(rst_i) |-> cts_n_o == PIN_ON && dsr_n_o == PIN_OFF && dcd_n_o == PIN_OFF)
    else $error("modem pins not at init levels");
  pullups_on_a: assert property (
    rts_pullup_o && dtr_pullup_o) else $error("pin pull-up disabled");
  cts_accept_a: assert property (
    $past(ctrl_q[CTRL_HWFC]) && $past(psv) == PSV_OFF
    |-> cts_n_o == !($past(ctrl_q[CTRL_UART_RDY]) || $past(ctrl_q[CTRL_MUX])))
    else $error("cts wrong for accept state");
  fc_cmd_a: assert property (
    ctrl_q[CTRL_HWFC] && ctrl_q[CTRL_MUX] && psv == PSV_OFF
    |-> mux_fc_on_o == ctrl_q[CTRL_UART_RDY]) else $error("mux flow command wrong");
  tx_stop_a: assert property (
    ctrl_q[CTRL_HWFC] && $past(rts_n_i, 2) |-> !tx_allow_o)
    else $error("tx allowed with rts off");
  dsr_track_a: assert property (
    $past(ctrl_q[CTRL_DSR_TRK]) |-> dsr_n_o == ($past(mode) != MODE_DATA))
    else $error("dsr does not track data mode");
  dsr_fixed_a: assert property (
    !$past(ctrl_q[CTRL_DSR_TRK]) |-> dsr_n_o == PIN_ON) else $error("fixed dsr not on");
  dcd_track_a: assert property (
    $past(ctrl_q[CTRL_DCD_TRK]) |-> dcd_n_o == !$past(req)) else $error("dcd request mismatch");
  dcd_fixed_a: assert property (
    !$past(ctrl_q[CTRL_DCD_TRK]) |-> dcd_n_o == PIN_ON) else $error("fixed dcd not on");
  wake_start_a: assert property (
    on_cnt_q == 5 |-> uart_en_o && rx_drop_o) else $error("uart not enabled by wake edge");
  wake_wait_a: assert property (
    on_cnt_q == WAKE_CYCLES |-> rx_drop_o) else $error("wake completed too early");
  wake_done_a: assert property (
    on_cnt_q == WAKE_CYCLES + 8 |-> !rx_drop_o && awake_o) else $error("wake not complete");
  line_sleep_a: assert property (
    psv_mode && $past(psv_mode, 3) && pin_n && $past(pin_n)
    && $past(pin_n, 2) && $past(pin_n, 3) |-> !uart_en_o)
    else $error("uart enabled with line off");
  ack_pulse_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule : umc_lines_asserts

// *** verif/umc_host_model.sv ***
/*
  umc_host_model: host terminal on the rts and dtr pins.
  assumes the bench commands each line; a released line follows its pull-up.
*/
`timescale 1ns/1ps
module umc_host_model
  import umc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rts_on_i,
  input  wire logic dtr_on_i,
  input  wire logic rts_pull_i,
  input  wire logic dtr_pull_i,
  input  wire logic tx_char_done_i,
  output logic       rts_n_o,
  output logic       dtr_n_o,
  output logic [7:0] late_o
);
  logic flip_q = 1'b0;

  // a released line with no pull-up wanders, so no stale level is seen
  always @(posedge clk_i) flip_q <= ~flip_q;

  // drive low for ON, release otherwise
  assign rts_n_o = rts_on_i ? PIN_ON : (rts_pull_i ? PIN_OFF : flip_q);
  assign dtr_n_o = dtr_on_i ? PIN_ON : (dtr_pull_i ? PIN_OFF : flip_q);

  // characters still taken after rts went OFF; the host has room for them
  initial late_o = 8'h00;
  always @(posedge clk_i) begin
    if (rts_on_i) late_o <= 8'h00;
    else if (tx_char_done_i) late_o <= late_o + 8'h01;
  end
endmodule : umc_host_model

// *** verif/testbench.sv ***
/*
  testbench: self-checking bench for umc_lines.
  assumes the host model on the pins; the bench plays the uart core.
*/
`timescale 1ns/1ps
module testbench;
  import umc_pkg::*;
  localparam int unsigned WAKE = 50;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] call; logic [2:0] pins;} umc_row_s;

  logic        clk_i          = 1'b0;
  logic        rst_i          = 1'b1;
  logic        wb_cyc_i       = 1'b0;
  logic        wb_stb_i       = 1'b0;
  logic        wb_we_i        = 1'b0;
  logic [3:0]  wb_adr_i       = 4'h0;
  logic [3:0]  wb_sel_i       = 4'hf;
  logic [31:0] wb_dat_i       = 32'h0000_0000;
  logic        rx_char_i      = 1'b0;
  logic        tx_char_done_i = 1'b0;
  logic        tx_req_i       = 1'b0;
  logic        rts_on         = 1'b0;
  logic        dtr_on         = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, rts_n_i, dtr_n_i, cts_n_o, dsr_n_o, dcd_n_o, awake_o;
  logic        rts_pullup_o, dtr_pullup_o, tx_allow_o, rx_drop_o, mux_fc_on_o, uart_en_o;
  logic [7:0]  late;
  int          checks   = 0;
  int          failures = 0;
  // ctrl, call, expected {cts, dsr, dcd}
  umc_row_s rows [15] = '{
    '{8'h4d, 8'h00, 3'h3}, '{8'h4d, 8'h01, 3'h1}, '{8'h4d, 8'h02, 3'h3},
    '{8'h4d, 8'h04, 3'h2}, '{8'h4d, 8'h09, 3'h0}, '{8'h4d, 8'h08, 3'h3},
    '{8'h4d, 8'h11, 3'h0}, '{8'h4d, 8'h10, 3'h3}, '{8'h4d, 8'h12, 3'h2},
    '{8'h4d, 8'h20, 3'h2}, '{8'h4d, 8'h22, 3'h2}, '{8'h4d, 8'h40, 3'h2},
    '{8'h41, 8'h00, 3'h0}, '{8'h0d, 8'h00, 3'h7}, '{8'h0f, 8'h00, 3'h3}
  };

  always #5 clk_i = ~clk_i;
  // one character takes two cycles and starts only while permitted
  always @(posedge clk_i) tx_char_done_i <= tx_req_i && tx_allow_o && !tx_char_done_i;

  umc_host_model host_u (.clk_i, .rts_on_i(rts_on), .dtr_on_i(dtr_on),
    .rts_pull_i(rts_pullup_o), .dtr_pull_i(dtr_pullup_o), .tx_char_done_i,
    .rts_n_o(rts_n_i), .dtr_n_o(dtr_n_i), .late_o(late));
  umc_lines #(.WAKE_CYCLES(WAKE)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rts_n_i, .dtr_n_i, .cts_n_o,
    .dsr_n_o, .dcd_n_o, .rts_pullup_o, .dtr_pullup_o, .rx_char_i, .tx_char_done_i,
    .tx_req_i, .tx_allow_o, .rx_drop_o, .mux_fc_on_o, .uart_en_o, .awake_o);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_io

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({29'h0, cts_n_o, dsr_n_o, dcd_n_o}, 32'h0000_0003);
    chk({30'h0, rts_pullup_o, dtr_pullup_o}, 32'h0000_0003);
    wb_io(1'b0, ADR_CTRL, 32'h0000_0000, rd);
    chk(rd, CTRL_RST);
    wb_io(1'b1, 4'hc, 32'hffff_ffff, rd);
    wb_io(1'b0, 4'hc, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    foreach (rows[i]) begin
      wb_io(1'b1, ADR_CTRL, {24'h0, rows[i].ctrl}, rd);
      wb_io(1'b1, ADR_CALL, {24'h0, rows[i].call}, rd);
      @(posedge clk_i);
      chk({29'h0, cts_n_o, dsr_n_o, dcd_n_o}, {29'h0, rows[i].pins});
    end
    // mux on and able to accept: flow control travels as a mux command
    wb_io(1'b1, ADR_CTRL, 32'h0000_0043, rd);
    @(posedge clk_i);
    chk({30'h0, mux_fc_on_o, cts_n_o}, 32'h0000_0002);
    // cyclic power save, no flow control, uart not ready: rx not valid
    wb_io(1'b1, ADR_CTRL, 32'h0000_001c, rd);
    chk({30'h0, uart_en_o, rx_drop_o}, 32'h0000_0001);
    // rts pause while the uart core keeps asking to send
    wb_io(1'b1, ADR_CTRL, 32'h0000_004d, rd);
    tx_req_i <= 1'b1;
    rts_on   <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({31'h0, tx_allow_o}, 32'h0000_0001);
    rts_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({31'h0, tx_allow_o}, 32'h0000_0000);
    chk({31'h0, late > 8'h02}, 32'h0000_0000);
    wb_io(1'b0, ADR_STAT, 32'h0000_0000, rd);
    chk({31'h0, rd[STAT_TX_PAUSE]}, 32'h0000_0001);
    tx_req_i <= 1'b0;
    // line-controlled power save, rts then dtr, no flow control
    for (int m = 2; m < 4; m++) begin
      wb_io(1'b1, ADR_CTRL, {25'h0, 1'b1, m[1:0], 4'hc}, rd);
      repeat (6) @(posedge clk_i);
      chk({30'h0, uart_en_o, rx_drop_o}, 32'h0000_0001);
      rx_char_i <= 1'b1;
      @(posedge clk_i);
      rx_char_i <= 1'b0;
      wb_io(1'b0, ADR_STAT, 32'h0000_0000, rd);
      chk({31'h0, rd[STAT_DROP1ST]}, 32'h0000_0001);
      rts_on <= (m == 2);
      dtr_on <= (m == 3);
      repeat (6) @(posedge clk_i);
      chk({30'h0, uart_en_o, rx_drop_o}, 32'h0000_0003);
      repeat (WAKE + 6) @(posedge clk_i);
      chk({29'h0, uart_en_o, rx_drop_o, awake_o}, 32'h0000_0005);
      rts_on <= 1'b0;
      dtr_on <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({31'h0, uart_en_o}, 32'h0000_0000);
    end
    // second reset in mid-run brings back the defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({29'h0, cts_n_o, dsr_n_o, dcd_n_o}, 32'h0000_0003);
    wb_io(1'b0, ADR_CTRL, 32'h0000_0000, rd);
    chk(rd, CTRL_RST);
    final_report();
  end

  // run is well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule : testbench

bind umc_lines umc_lines_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .rts_n_i,
  .dtr_n_i, .cts_n_o, .dsr_n_o, .dcd_n_o, .rts_pullup_o, .dtr_pullup_o, .tx_allow_o,
  .mux_fc_on_o, .uart_en_o, .rx_drop_o, .awake_o);
